// File: hw/spcl_top.sv
// serial port control, low-power and interrupt block with apb registers
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "spcl_consts.svh"

module spcl_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic cpu_irq_mask,
    output logic irq_req,
    output logic wake_req,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_b,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_b,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_b,
    input wire logic ss_i
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;
    logic [3:0] sy1, sy2, sy3, pin_f;
    spcl_pkg::spcl_ctrl_s ctrl;
    spcl_pkg::spcl_stat_s stat;
    spcl_pkg::spcl_xfer_e state;
    logic [4:0] edge_cnt;
    logic [7:0] sh, rx_buf, next_sh;
    logic done_armed, fault_armed, halt_q, halt_ok, halt_resid;
    logic gen_sck, gen_tick, eff_ss, tgt, frz, flag_any;
    logic acc, wr, rd, data_acc, data_wr, ctrl_wr, stat_acc, stat_rd;
    logic tgt_edge, sck_edge, in_bit, byte_done, data_load, fault_evt;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // pin synchronisers: ss, sck, mosi, miso
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sy1[gi] <= 1'b1;
                    sy2[gi] <= 1'b1;
                    sy3[gi] <= 1'b1;
                    pin_f[gi] <= 1'b1;
                end else begin
                    sy1[gi] <= (gi == 3) ? ss_i : (gi == 2) ? sck_i
                        : (gi == 1) ? mosi_i : miso_i;
                    sy2[gi] <= sy1[gi];
                    sy3[gi] <= sy2[gi];
                    if (sy2[gi] == sy3[gi]) begin
                        pin_f[gi] <= sy3[gi];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // mode terms
    // ----------------------------------------
    assign eff_ss = stat.soft_select_mode ? stat.soft_target_select_level : pin_f[3];
    assign tgt = !ctrl.controller_select;
    // halt freezes the bus, control, shift and status logic unless a target may still wake
    assign frz = halt_mode && !(tgt && halt_ok);
    assign fault_evt = ctrl.controller_select && ctrl.port_enable && !eff_ss;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // one wait state: pready is a flop raised in the first access cycle
    assign acc = psel && penable && pready && !frz;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign data_acc = acc && hit(paddr, `SPCL_OFF_DATA);
    assign data_wr = wr && hit(paddr, `SPCL_OFF_DATA);
    assign ctrl_wr = wr && hit(paddr, `SPCL_OFF_CTRL);
    assign stat_acc = acc && hit(paddr, `SPCL_OFF_STAT);
    assign stat_rd = rd && hit(paddr, `SPCL_OFF_STAT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready && !frz;
            pslverr <= psel && penable && !pready && !frz && !(hit(paddr, `SPCL_OFF_DATA)
                || hit(paddr, `SPCL_OFF_CTRL) || hit(paddr, `SPCL_OFF_STAT)
                || hit(paddr, `SPCL_OFF_LP));
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    `SPCL_OFF_DATA: prdata <= {24'h00_0000, rx_buf};
                    `SPCL_OFF_CTRL: prdata <= {24'h00_0000, ctrl};
                    `SPCL_OFF_STAT: prdata <= {24'h00_0000, stat};
                    `SPCL_OFF_LP: prdata <= {30'h0000_0000, halt_ok, halt_resid};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `SPCL_CTRL_RST;
        end else if (!frz) begin
            if (ctrl_wr) begin
                ctrl <= pwdata[7:0];
                // enable and controller stay off while a fault is unacknowledged
                if (stat.controller_fault_flag && !fault_armed) begin
                    ctrl.port_enable <= 1'b0;
                    ctrl.controller_select <= 1'b0;
                end
            end
            if (fault_evt) begin
                ctrl.port_enable <= 1'b0;
                ctrl.controller_select <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // controller clock
    // ----------------------------------------
    spcl_sck_gen u_sck_gen (
        .clk(clk),
        .rst_n(rst_n),
        .run(state == spcl_pkg::SPCL_SHIFT && ctrl.controller_select && !frz),
        .idle_level(ctrl.clock_idle_level),
        .rate({ctrl.halve_bypass_bit, ctrl.clock_rate_select}),
        .sck(gen_sck),
        .tick(gen_tick)
    );

    // ----------------------------------------
    // shift engine
    // ----------------------------------------
    // target edges only while selected and enabled
    assign tgt_edge = (sy2[2] == sy3[2]) && (sy3[2] != pin_f[2])
        && tgt && ctrl.port_enable && !eff_ss;
    assign sck_edge = ctrl.controller_select ? gen_tick : tgt_edge;
    assign in_bit = ctrl.controller_select ? pin_f[0] : pin_f[1];
    assign next_sh = {sh[6:0], in_bit};
    assign byte_done = sck_edge && (edge_cnt == `SPCL_EDGES_LAST) && !frz;
    // writes refused while done is set and not yet acknowledged
    assign data_load = data_wr && !(stat.transfer_done_flag && !done_armed)
        && state == spcl_pkg::SPCL_IDLE;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= spcl_pkg::SPCL_IDLE;
            edge_cnt <= 5'h00;
            sh <= 8'h00;
        end else if (!frz) begin
            unique case (state)
                spcl_pkg::SPCL_IDLE: begin
                    if (data_load) begin
                        sh <= pwdata[7:0];
                        if (ctrl.controller_select && ctrl.port_enable) begin
                            state <= spcl_pkg::SPCL_SHIFT;
                        end
                    end else if (tgt_edge) begin
                        state <= spcl_pkg::SPCL_SHIFT;
                        edge_cnt <= 5'h01;
                        if (!ctrl.clock_capture_phase) begin
                            sh <= next_sh;
                        end
                    end
                end
                spcl_pkg::SPCL_SHIFT: begin
                    if (!ctrl.port_enable || (tgt && eff_ss)) begin
                        // deselect or disable aborts the byte
                        state <= spcl_pkg::SPCL_IDLE;
                        edge_cnt <= 5'h00;
                    end else if (sck_edge) begin
                        if (edge_cnt[0] == ctrl.clock_capture_phase) begin
                            sh <= next_sh;
                        end
                        if (edge_cnt == `SPCL_EDGES_LAST) begin
                            state <= spcl_pkg::SPCL_IDLE;
                            edge_cnt <= 5'h00;
                        end else begin
                            edge_cnt <= edge_cnt + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // receive buffer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf <= 8'h00;
        end else if (byte_done && !stat.transfer_done_flag) begin
            // first byte since the last clear is kept, later ones dropped
            rx_buf <= ctrl.clock_capture_phase ? next_sh : sh;
        end
    end

    // ----------------------------------------
    // status flags: hardware set wins over clear
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat <= `SPCL_STAT_RST;
            done_armed <= 1'b0;
        end else if (!frz) begin
            if (stat_acc && stat.transfer_done_flag) begin
                done_armed <= 1'b1;
            end
            if (data_acc && done_armed) begin
                stat.transfer_done_flag <= 1'b0;
                stat.collision_flag <= 1'b0;
                done_armed <= 1'b0;
            end
            if (byte_done) begin
                stat.transfer_done_flag <= 1'b1;
            end
            if (data_wr && state == spcl_pkg::SPCL_SHIFT) begin
                stat.collision_flag <= 1'b1;
            end
            if (stat_rd) begin
                stat.overrun_flag <= 1'b0;
            end
            if (byte_done && stat.transfer_done_flag) begin
                stat.overrun_flag <= 1'b1;
            end
            if (ctrl_wr && fault_armed) begin
                stat.controller_fault_flag <= 1'b0;
            end
            if (fault_evt) begin
                stat.controller_fault_flag <= 1'b1;
            end
            if (wr && hit(paddr, `SPCL_OFF_STAT)) begin
                stat[2:0] <= 3'(pwdata[7:0] & `SPCL_STAT_WMASK);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_armed <= 1'b0;
        end else if (!frz) begin
            if (stat_rd && stat.controller_fault_flag) begin
                fault_armed <= 1'b1;
            end else if (ctrl_wr || !stat.controller_fault_flag) begin
                fault_armed <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // halt tracking
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_q <= 1'b0;
            halt_ok <= 1'b0;
        end else begin
            halt_q <= halt_mode;
            if (halt_mode && !halt_q) begin
                // select level caught at the entry edge decides wake ability
                halt_ok <= tgt && ctrl.port_enable && !eff_ss;
            end else if (!halt_mode) begin
                halt_ok <= 1'b0;
            end
        end
    end

    // byte taken in halt leaves the port marked until a byte ends outside halt or controller is selected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_resid <= 1'b0;
        end else if (byte_done && halt_mode && tgt) begin
            halt_resid <= 1'b1;
        end else if (byte_done || ctrl.controller_select) begin
            halt_resid <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupt and wake requests
    // ----------------------------------------
    assign flag_any = stat.transfer_done_flag || stat.controller_fault_flag
        || stat.overrun_flag;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq_req <= ctrl.port_irq_enable && flag_any && !cpu_irq_mask;
            if (halt_mode) begin
                // only the done event may leave halt; a fault may not
                wake_req <= ctrl.port_irq_enable && !cpu_irq_mask && halt_ok
                    && (stat.transfer_done_flag || byte_done);
            end else begin
                wake_req <= wait_mode && ctrl.port_irq_enable && flag_any
                    && !cpu_irq_mask;
            end
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_o <= 1'b0;
            sck_oe_b <= 1'b1;
            mosi_o <= 1'b0;
            mosi_oe_b <= 1'b1;
            miso_o <= 1'b0;
            miso_oe_b <= 1'b1;
        end else begin
            sck_o <= gen_sck;
            mosi_o <= sh[7];
            miso_o <= sh[7];
            // disabled port releases every pin to general-purpose use
            sck_oe_b <= !(ctrl.port_enable && ctrl.controller_select);
            mosi_oe_b <= !(ctrl.port_enable && ctrl.controller_select
                && !stat.output_disable);
            miso_oe_b <= !(ctrl.port_enable && tgt && !eff_ss
                && !stat.output_disable);
        end
    end

endmodule

// File: hw/spcl_consts.svh
// constants for the serial port control, low-power and interrupt block
//
// Behaviour
// - wait mode: port runs, events wake
// - halt: port frozen until waking interrupt
// - halt target byte sets done, wakes
// - second byte before clear sets overrun
// - halt wake only if select was low
// - one vector; enable set, cpu mask clear
// - bit 7 gates all port interrupts
// - bit 6 enable; fault clears; pins released
// - bit 5 low adds divide by two (code: for rate bits 00 and 10 only)
// - bit 4 controller; pins swap; fault clears
// - bit 3 sets clock idle level
// - bit 2 picks first capture edge
// - both ends share idle level and phase
// - rate bits divide cpu clock 4..128
// - control upper nibble resets to zero
// - controller sees select low: fault
// - overrun keeps first byte, drops later
// - done flag cleared by status, data access
`ifndef SPCL_CONSTS_SVH
`define SPCL_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPCL_OFF_DATA 8'h00
`define SPCL_OFF_CTRL 8'h04
`define SPCL_OFF_STAT 8'h08
`define SPCL_OFF_LP 8'h0C

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define SPCL_CTRL_RST 8'h00
`define SPCL_STAT_RST 8'h00
`define SPCL_STAT_WMASK 8'h07

// ----------------------------------------
// timing counts
// ----------------------------------------
`define SPCL_EDGES_LAST 5'h0F
`define SPCL_HALF_4 7'h02
`define SPCL_HALF_8 7'h04
`define SPCL_HALF_16 7'h08
`define SPCL_HALF_32 7'h10
`define SPCL_HALF_64 7'h20
`define SPCL_HALF_128 7'h40

`endif

// File: hw/spcl_pkg.sv
// types of the serial port control block
package spcl_pkg;

    typedef struct packed {
        logic port_irq_enable;
        logic port_enable;
        logic halve_bypass_bit;
        logic controller_select;
        logic clock_idle_level;
        logic clock_capture_phase;
        logic [1:0] clock_rate_select;
    } spcl_ctrl_s;

    typedef struct packed {
        logic transfer_done_flag;
        logic collision_flag;
        logic overrun_flag;
        logic controller_fault_flag;
        logic reserved;
        logic output_disable;
        logic soft_select_mode;
        logic soft_target_select_level;
    } spcl_stat_s;

    typedef enum logic [1:0] {
        SPCL_IDLE = 2'b01,
        SPCL_SHIFT = 2'b10
    } spcl_xfer_e;

endpackage

// File: hw/spcl_sck_gen.sv
// controller-mode serial clock divider
`timescale 1ns/1ns
`include "spcl_consts.svh"

module spcl_sck_gen (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic idle_level,
    input wire logic [2:0] rate,
    output logic sck,
    output logic tick
);

    logic [6:0] cnt;
    logic [6:0] half;

    // ----------------------------------------
    // rate decode
    // ----------------------------------------
    function automatic logic [6:0] half_of(input logic [2:0] r);
        case (r)
            3'h4: half_of = `SPCL_HALF_4;
            3'h0: half_of = `SPCL_HALF_8;
            3'h1: half_of = `SPCL_HALF_16;
            3'h6: half_of = `SPCL_HALF_32;
            3'h2: half_of = `SPCL_HALF_64;
            default: half_of = `SPCL_HALF_128;
        endcase
    endfunction

    assign half = half_of(rate);

    // ----------------------------------------
    // divider
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 7'h00;
            sck <= 1'b0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt <= 7'h00;
            sck <= idle_level;
            tick <= 1'b0;
        end else if (cnt == half - 7'h01) begin
            cnt <= 7'h00;
            sck <= ~sck;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 7'h01;
            tick <= 1'b0;
        end
    end

endmodule

// File: testbench/spcl_asserts.sv
// assertion checker for the serial port control block
`timescale 1ns/1ns
module spcl_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic cpu_irq_mask,
    input wire logic irq_req,
    input wire logic wake_req,
    input wire logic sck_o,
    input wire logic sck_oe_b,
    input wire logic miso_oe_b,
    input wire logic ss_i
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------
    // bus answer
    // ----------
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_answer: assert property (psel && penable && !pready && !halt_mode |=> pready)
        else $error("no answer one cycle into access");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // ----------
    // interrupts and wake
    // ----------
    a_irq_masked: assert property (cpu_irq_mask |=> !irq_req)
        else $error("interrupt while cpu masks");
    a_wake_masked: assert property (cpu_irq_mask |=> !wake_req)
        else $error("wake while cpu masks");
    a_wait_wake: assert property (wait_mode && !halt_mode ##1 irq_req |-> wake_req)
        else $error("interrupt in wait without wake");
    // ----------
    // pins
    // ----------
    a_one_driver: assert property (!sck_oe_b |-> miso_oe_b)
        else $error("clock and target output driven together");
    a_sck_pace: assert property (!sck_oe_b && $changed(sck_o) |=> $stable(sck_o))
        else $error("clock faster than divide by four");
    a_fault_release: assert property ((!sck_oe_b && !ss_i)[*3] |-> ##[0:6] sck_oe_b)
        else $error("controller kept driving with select low");
endmodule

// File: testbench/spcl_far_model.sv
// far-end link controller model driving the port's pins
`timescale 1ns/1ns
module spcl_far_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    output logic sck,
    output logic mosi,
    output logic miso,
    output logic sel_b
);
    initial begin
        sck = 1'h0;
        mosi = 1'h0;
        miso = 1'h0;
        sel_b = 1'h1;
    end
    // released target line: toggles so a stale level never reads as data
    always @(posedge clk) miso <= ~miso;
    task automatic set_sel(input logic v);
        sel_b <= v;
    endtask
    // clock idles low, as the port is set up; phase given by caller
    task automatic send(input logic [7:0] b, input logic ph);
        for (int i = 7; i >= 0; i--) begin
            if (ph) sck <= 1'h1;
            mosi <= b[i];
            repeat (HALF) @(posedge clk);
            sck <= ~ph;
            repeat (HALF) @(posedge clk);
            if (!ph) sck <= 1'h0;
        end
        repeat (HALF) @(posedge clk);
        mosi <= ~mosi;
        @(posedge clk);
    endtask
endmodule

// File: testbench/tb_top.sv
// top-level bench for the serial port control block
`timescale 1ns/1ns
module tb_top;
    logic clk, rst_b, psel, penable, pwrite, halt_mode, wait_mode, cpu_irq_mask;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq_req, wake_req, sck_o, sck_oe_b, mosi_o, mosi_oe_b;
    logic miso_o, miso_oe_b, far_sck, far_mosi, far_miso, far_sel_b, err;
    logic sck_w, mosi_w, miso_w, s, idle, ph;
    logic [2:0] code;
    int n;
    int num_errors = 0;
    int checked = 0;
    logic [9:0] rows [6] = '{{3'h4, 7'h02}, {3'h0, 7'h04}, {3'h1, 7'h08},
        {3'h6, 7'h10}, {3'h2, 7'h20}, {3'h3, 7'h40}};
    assign sck_w = sck_oe_b ? far_sck : sck_o;
    assign mosi_w = mosi_oe_b ? far_mosi : mosi_o;
    assign miso_w = miso_oe_b ? far_miso : miso_o;
    spcl_top u_spcl_top (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .halt_mode, .wait_mode, .cpu_irq_mask, .irq_req, .wake_req,
        .sck_i(sck_w), .sck_o, .sck_oe_b, .mosi_i(mosi_w), .mosi_o, .mosi_oe_b,
        .miso_i(miso_w), .miso_o, .miso_oe_b, .ss_i(far_sel_b));
    spcl_far_model u_spcl_far_model (.clk, .sck(far_sck), .mosi(far_mosi), .miso(far_miso),
        .sel_b(far_sel_b));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // ----------
    // shared tasks
    // ----------
    task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdchk(input string w, input logic [7:0] a, input logic [7:0] m,
            input logic [7:0] e);
        apb(1'h0, a, 32'h0);
        chk(w, rd & {24'h0, m}, {24'h0, e});
    endtask
    // bounded only by the watchdog; a stuck flag ends the run
    task automatic wait_done();
        do apb(1'h0, 8'h08, 32'h0); while (rd[7] !== 1'h1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        rst_b = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        halt_mode = 1'h0;
        wait_mode = 1'h0;
        cpu_irq_mask = 1'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        rdchk("control reset", 8'h04, 8'hF0, 8'h00);
        rdchk("status reset", 8'h08, 8'hFF, 8'h00);
        apb(1'h0, 8'h10, 32'h0);
        chk("unmapped error", err, 1'h1);
        apb(1'h1, 8'h04, 32'hAF);
        rdchk("control readback", 8'h04, 8'hFF, 8'hAF);
        // controller bytes at every rate, run in wait mode
        wait_mode <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            code = rows[i][9:7];
            idle = i[0];
            ph = i[1];
            apb(1'h1, 8'h04, 32'h0);
            apb(1'h1, 8'h04, {24'h0, 2'h3, code[2], 1'h1, idle, ph, code[1:0]});
            apb(1'h1, 8'h00, 32'h5A);
            s = sck_o;
            while (sck_o === s) @(posedge clk);
            s = sck_o;
            n = 0;
            while (sck_o === s) begin
                @(posedge clk);
                n++;
            end
            chk("sck half period", n, {25'h0, rows[i][6:0]});
            wait_done();
            @(posedge clk);
            chk("sck idle", sck_o, idle);
            chk("sck driven", sck_oe_b, 1'h0);
            chk("mosi driven", mosi_oe_b, 1'h0);
            chk("done irq", irq_req, 1'h1);
            chk("wake in wait", wake_req, 1'h1);
            apb(1'h0, 8'h00, 32'h0);
            repeat (2) @(posedge clk);
            chk("irq after clear", irq_req, 1'h0);
        end
        wait_mode <= 1'h0;
        apb(1'h1, 8'h04, 32'h0);
        // controller sees select low
        cpu_irq_mask <= 1'h1;
        apb(1'h1, 8'h04, 32'hD0);
        u_spcl_far_model.set_sel(1'h0);
        repeat (10) @(posedge clk);
        rdchk("fault flag", 8'h08, 8'h10, 8'h10);
        rdchk("enable, controller off", 8'h04, 8'h50, 8'h00);
        chk("pins released", sck_oe_b & mosi_oe_b & miso_oe_b, 1'h1);
        chk("masked irq", irq_req, 1'h0);
        cpu_irq_mask <= 1'h0;
        repeat (3) @(posedge clk);
        chk("fault irq", irq_req, 1'h1);
        u_spcl_far_model.set_sel(1'h1);
        apb(1'h1, 8'h04, 32'h0);
        rdchk("fault cleared", 8'h08, 8'h10, 8'h00);
        // target wakes from halt, then two bytes inside one halt
        apb(1'h1, 8'h04, 32'hC4);
        u_spcl_far_model.set_sel(1'h0);
        repeat (5) @(posedge clk);
        halt_mode <= 1'h1;
        u_spcl_far_model.send(8'h3C, 1'h1);
        repeat (8) @(posedge clk);
        chk("halt wake", wake_req, 1'h1);
        halt_mode <= 1'h0;
        rdchk("done after wake", 8'h08, 8'h80, 8'h80);
        rdchk("received byte", 8'h00, 8'hFF, 8'h3C);
        chk("target drives", miso_oe_b, 1'h0);
        halt_mode <= 1'h1;
        u_spcl_far_model.send(8'h81, 1'h1);
        u_spcl_far_model.send(8'h42, 1'h1);
        repeat (8) @(posedge clk);
        halt_mode <= 1'h0;
        rdchk("overrun flag", 8'h08, 8'hA0, 8'hA0);
        rdchk("first byte kept", 8'h00, 8'hFF, 8'h81);
        rdchk("halt residue", 8'h0C, 8'h03, 8'h01);
        u_spcl_far_model.send(8'h00, 1'h1);
        wait_done();
        apb(1'h0, 8'h00, 32'h0);
        rdchk("residue cleared", 8'h0C, 8'h03, 8'h00);
        // select high at halt entry: no wake, block frozen
        u_spcl_far_model.set_sel(1'h1);
        repeat (5) @(posedge clk);
        halt_mode <= 1'h1;
        u_spcl_far_model.set_sel(1'h0);
        u_spcl_far_model.send(8'h55, 1'h1);
        repeat (8) @(posedge clk);
        chk("no wake", wake_req, 1'h0);
        halt_mode <= 1'h0;
        rdchk("frozen in halt", 8'h08, 8'h80, 8'h00);
        tally_and_finish();
    end
endmodule
bind spcl_top spcl_asserts u_spcl_asserts (.clk, .rst_b, .psel, .penable, .prdata, .pready,
    .pslverr, .halt_mode, .wait_mode, .cpu_irq_mask, .irq_req, .wake_req, .sck_o, .sck_oe_b,
    .miso_oe_b, .ss_i);
